// ==== clkg_pkg.sv ====
// Package of constants for the clock generator control block
// Operation
// - Wake-up switch on: wake-up copies wake source and divider into system selection.
// - Wake-up switch off: system selection unchanged at wake-up; wake fields unused.
// - Source codes internal/sub/main/external; per-source divider set; other combinations reserved.
// - Wake-up fields use the same source codes, dividers and reserved entries.
// - Selecting a stopped source as system clock starts that source.
// - Stopped wake-up source starts automatically at wake-up when switch enabled.
// - Per-source sleep bits: 1 stops source in SLEEP, 0 keeps state; reset 1.
// - Per-source enable bits start or stop source; only internal enabled after reset.
// - Trim start bit begins trimming, reads 1 while running, self-clears; 0 stops.
// - Trimming never runs while sub oscillator stopped; software checks settled flag.
// - Frequency field picks 4, 8, 12 or 16 MHz; resets to code 1.
// - Stop detector enable switches detector; restart enable restarts sub oscillator.
// - Boost enable: boost gain during startup, normal gain after; resets 2 and 1.
// - Sub wait field: 4096, 16384 or 65536 clocks; code 0 reserved; reset 2.
// - Main wait field: 4 to 65536 clocks by powers of four; reset 6.
// - Five flags set on cause, cleared by writing 1, writing 0 ignored; reset 0.
// - Internal settled flag reads 0 after reset although oscillator already stable.
// - Gate capacitance field and main gain field held and driven; main gain resets 3.
// - Protected fields writable only while protection key holds 0x0096.
// - Interrupt request only while a flag is set and its enable bit is 1.
// - Sub stop flag sets on clock stop or enable/detector enable falling.
package clkg_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [5:0] OFS_SYS_SEL = 6'h00;
  localparam logic [5:0] OFS_SRC_EN = 6'h04;
  localparam logic [5:0] OFS_INTERNAL_OSCILLATOR = 6'h08;
  localparam logic [5:0] OFS_SUB = 6'h0c;
  localparam logic [5:0] OFS_MAIN = 6'h10;
  localparam logic [5:0] OFS_FLAGS = 6'h14;
  localparam logic [5:0] OFS_IRQ_EN = 6'h18;
  localparam logic [5:0] OFS_KEY = 6'h1c;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SEL_WAKE_SW = 15;
  localparam int SEL_WAKE_DIV = 12;
  localparam int SEL_WAKE_SRC = 8;
  localparam int SEL_DIV = 4;
  localparam int SEL_SRC = 0;
  localparam int EN_SLEEP = 8;
  localparam int EN_RUN = 0;
  localparam int INTERNAL_OSCILLATOR_TRIM = 4;
  localparam int INTERNAL_OSCILLATOR_FREQ = 0;
  localparam int SUB_RESTART = 14;
  localparam int SUB_DETECT = 13;
  localparam int SUB_BOOST = 12;
  localparam int SUB_CAP = 8;
  localparam int SUB_BGAIN = 6;
  localparam int SUB_NGAIN = 4;
  localparam int SUB_WAIT = 0;
  localparam int MAIN_GAIN = 4;
  localparam int MAIN_WAIT = 0;
  localparam int FLG_INT_SET = 0;
  localparam int FLG_SUB_SET = 1;
  localparam int FLG_MAIN_SET = 2;
  localparam int FLG_TRIM = 4;
  localparam int FLG_SUB_STOP = 5;
  // ----------------------------------------------------------------
  // Reset values and writable masks
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_SYS_SEL = 16'h0000;
  localparam logic [15:0] RST_SRC_EN = 16'h0f01;
  localparam logic [15:0] RST_INTERNAL_OSCILLATOR = 16'h0001;
  localparam logic [15:0] RST_SUB = 16'h5092;
  localparam logic [15:0] RST_MAIN = 16'h0036;
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [15:0] MSK_SYS_SEL = 16'hb333;
  localparam logic [15:0] MSK_SRC_EN = 16'h0f0f;
  localparam logic [15:0] MSK_INTERNAL_OSCILLATOR = 16'h0013;
  localparam logic [15:0] MSK_SUB = 16'h77f3;
  localparam logic [15:0] MSK_MAIN = 16'h0037;
  localparam logic [15:0] MSK_IRQ = 16'h0037;
  localparam logic [15:0] PROT_KEY = 16'h0096;
  // ----------------------------------------------------------------
  // Source codes and stabilization counts (source clocks)
  // ----------------------------------------------------------------
  localparam logic [1:0] SRC_INT = 2'h0;
  localparam logic [1:0] SRC_SUB = 2'h1;
  localparam logic [1:0] SRC_MAIN = 2'h2;
  localparam logic [1:0] SRC_EXT = 2'h3;
  localparam logic [16:0] WAIT_SUB_1 = 17'h01000;
  localparam logic [16:0] WAIT_SUB_2 = 17'h04000;
  localparam logic [16:0] WAIT_SUB_3 = 17'h10000;
  localparam logic [16:0] WAIT_MAIN_BASE = 17'h00004;
  localparam logic [16:0] WAIT_INT = 17'h00100;
  localparam logic [16:0] WAIT_EXT = 17'h00001;
  localparam int STOP_TIMEOUT_CYC = 16384;
endpackage : clkg_pkg

// ==== clkg_ctrl.sv ====
// Clock generator control: registers, source control, settle counters, switching
`timescale 1ns/10ps
module clkg_ctrl #(
  parameter int STOP_TIMEOUT = clkg_pkg::STOP_TIMEOUT_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic sleep_req,
  input wire logic wakeup,
  input wire logic [3:0] osc_clk_in,
  input wire logic trim_done_in,
  output logic [3:0] osc_run,
  output logic [1:0] sys_clk_src,
  output logic [1:0] sys_clk_div,
  output logic sleeping,
  output logic [1:0] internal_freq_sel,
  output logic trim_run,
  output logic [2:0] gate_cap_sel,
  output logic [1:0] sub_gain,
  output logic [1:0] main_gain_sel,
  output logic stop_detector_on,
  output logic sub_restart,
  output logic irq
);
  import clkg_pkg::*;

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [15:0] sys_sel, src_en, internal_oscillator_ctl, sub_ctl, main_ctl, flags, irq_en, prot_key;
  logic [15:0] next_sys_sel, next_src_en, next_internal_oscillator_ctl, next_sub_ctl;
  logic ack;
  logic wr_fire;
  logic [15:0] lane;
  logic prot_open;
  logic [3:0] settled;
  logic [3:0] settle_hit;
  logic wake_fire;
  logic stop_hit;
  logic trim_edge;
  logic sub_en_q, detect_q;

  // ----------------------------------------------------------------
  // Avalon-MM slave: one wait state for every access
  // ----------------------------------------------------------------
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign wr_fire = avs_write & ack;
  assign lane = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign prot_open = (prot_key == PROT_KEY);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read | avs_write) & ~ack;
    end
  end

  // Read data latched in the wait cycle, stable while waitrequest is low
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read & ~ack) begin
      case (avs_address)
        OFS_SYS_SEL: avs_readdata <= {16'h0000, sys_sel};
        OFS_SRC_EN: avs_readdata <= {16'h0000, src_en};
        OFS_INTERNAL_OSCILLATOR: avs_readdata <= {16'h0000, internal_oscillator_ctl};
        OFS_SUB: avs_readdata <= {16'h0000, sub_ctl};
        OFS_MAIN: avs_readdata <= {16'h0000, main_ctl};
        OFS_FLAGS: avs_readdata <= {16'h0000, flags};
        OFS_IRQ_EN: avs_readdata <= {16'h0000, irq_en};
        OFS_KEY: avs_readdata <= {16'h0000, prot_key};
        default: avs_readdata <= 32'h00000000;
      endcase
    end
  end

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] msk);
    merge = (old & ~msk) | (avs_writedata[15:0] & msk);
  endfunction : merge

  // ----------------------------------------------------------------
  // Sleep state and wake-up
  // ----------------------------------------------------------------
  assign wake_fire = sleeping & wakeup;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sleeping <= 1'b0;
    end else if (wake_fire) begin
      sleeping <= 1'b0;
    end else if (sleep_req) begin
      sleeping <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // System clock selection register
  // ----------------------------------------------------------------
  always_comb begin
    next_sys_sel = sys_sel;
    if (wr_fire && avs_address == OFS_SYS_SEL && prot_open) begin
      next_sys_sel = merge(sys_sel, MSK_SYS_SEL & lane);
    end
    if (wake_fire && sys_sel[SEL_WAKE_SW]) begin
      next_sys_sel[SEL_SRC +: 2] = sys_sel[SEL_WAKE_SRC +: 2];
      next_sys_sel[SEL_DIV +: 2] = sys_sel[SEL_WAKE_DIV +: 2];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sys_sel <= RST_SYS_SEL;
    end else begin
      sys_sel <= next_sys_sel;
    end
  end

  // ----------------------------------------------------------------
  // Source enables and sleep bits
  // ----------------------------------------------------------------
  always_comb begin
    next_src_en = src_en;
    if (wr_fire && avs_address == OFS_SRC_EN) begin
      next_src_en = merge(src_en, MSK_SRC_EN & lane);
    end
    if (next_sys_sel[SEL_SRC +: 2] != sys_sel[SEL_SRC +: 2]) begin
      next_src_en[EN_RUN + next_sys_sel[SEL_SRC +: 2]] = 1'b1;
    end
    if (wake_fire && sys_sel[SEL_WAKE_SW]) begin
      next_src_en[EN_RUN + sys_sel[SEL_WAKE_SRC +: 2]] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      src_en <= RST_SRC_EN;
    end else begin
      src_en <= next_src_en;
    end
  end

  // Sleep stops only sources marked to stop
  assign osc_run = src_en[EN_RUN +: 4] & ~({4{sleeping}} & src_en[EN_SLEEP +: 4]);

  // ----------------------------------------------------------------
  // Internal oscillator control and trimming
  // ----------------------------------------------------------------
  always_comb begin
    next_internal_oscillator_ctl = internal_oscillator_ctl;
    // Trim start and stop by software
    if (wr_fire && avs_address == OFS_INTERNAL_OSCILLATOR && prot_open) begin
      next_internal_oscillator_ctl = merge(internal_oscillator_ctl, MSK_INTERNAL_OSCILLATOR & lane);
    end
    if (trim_edge) begin
      next_internal_oscillator_ctl[INTERNAL_OSCILLATOR_TRIM] = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      internal_oscillator_ctl <= RST_INTERNAL_OSCILLATOR;
    end else begin
      internal_oscillator_ctl <= next_internal_oscillator_ctl;
    end
  end

  assign internal_freq_sel = internal_oscillator_ctl[INTERNAL_OSCILLATOR_FREQ +: 2];
  // No trimming without a running sub clock
  assign trim_run = internal_oscillator_ctl[INTERNAL_OSCILLATOR_TRIM] & osc_run[SRC_SUB] & settled[SRC_SUB];

  // ----------------------------------------------------------------
  // Sub and main oscillator control
  // ----------------------------------------------------------------
  always_comb begin
    next_sub_ctl = sub_ctl;
    if (wr_fire && avs_address == OFS_SUB && prot_open) begin
      next_sub_ctl = merge(sub_ctl, MSK_SUB & lane);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sub_ctl <= RST_SUB;
      main_ctl <= RST_MAIN;
    end else begin
      sub_ctl <= next_sub_ctl;
      if (wr_fire && avs_address == OFS_MAIN && prot_open) begin
        main_ctl <= merge(main_ctl, MSK_MAIN & lane);
      end
    end
  end

  assign gate_cap_sel = sub_ctl[SUB_CAP +: 3];
  assign main_gain_sel = main_ctl[MAIN_GAIN +: 2];
  // Boost gain until the sub clock settles
  assign sub_gain = (sub_ctl[SUB_BOOST] && !settled[SRC_SUB]) ? sub_ctl[SUB_BGAIN +: 2] : sub_ctl[SUB_NGAIN +: 2];
  // Detector on whenever its enable bit is set, independent of the sub clock enable
  assign stop_detector_on = sub_ctl[SUB_DETECT];

  // ----------------------------------------------------------------
  // Clock input synchronisers and edge detect
  // ----------------------------------------------------------------
  logic [4:0] in_s1, in_s2, in_s3;
  logic [3:0] clk_edge;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      in_s1 <= 5'h00;
      in_s2 <= 5'h00;
      in_s3 <= 5'h00;
    end else begin
      in_s1 <= {trim_done_in, osc_clk_in};
      in_s2 <= in_s1;
      in_s3 <= in_s2;
    end
  end

  // Inputs must be slower than half of clk_sys to be counted
  assign clk_edge = in_s2[3:0] & ~in_s3[3:0];
  assign trim_edge = in_s2[4] & ~in_s3[4] & internal_oscillator_ctl[INTERNAL_OSCILLATOR_TRIM];

  // ----------------------------------------------------------------
  // Stabilization counters, one per source
  // ----------------------------------------------------------------
  logic [16:0] target [4];
  always_comb begin
    target[SRC_INT] = WAIT_INT;
    // Sub wait table; reserved code treated as longest
    case (sub_ctl[SUB_WAIT +: 2])
      2'h1: target[SRC_SUB] = WAIT_SUB_1;
      2'h2: target[SRC_SUB] = WAIT_SUB_2;
      default: target[SRC_SUB] = WAIT_SUB_3;
    endcase
    // Main wait in powers of four
    target[SRC_MAIN] = 17'(WAIT_MAIN_BASE << {main_ctl[MAIN_WAIT +: 3], 1'b0});
    target[SRC_EXT] = WAIT_EXT;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_settle
      logic [16:0] cnt;
      logic done;
      logic restart_now;
      assign restart_now = (gi == SRC_SUB) ? sub_restart : 1'b0;
      assign settled[gi] = done;
      assign settle_hit[gi] = osc_run[gi] & ~restart_now & ~settled[gi] & clk_edge[gi] & (cnt + 17'h00001 >= target[gi]);
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          cnt <= 17'h00000;
          done <= (gi == SRC_INT);
        end else if (!osc_run[gi] || restart_now) begin
          cnt <= 17'h00000;
          done <= 1'b0;
        end else if (settle_hit[gi]) begin
          done <= 1'b1;
        end else if (!settled[gi] && clk_edge[gi]) begin
          cnt <= cnt + 17'h00001;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Sub oscillator stop detector
  // ----------------------------------------------------------------
  logic [$clog2(STOP_TIMEOUT + 1)-1:0] stop_cnt;
  assign stop_hit = stop_detector_on & osc_run[SRC_SUB] & settled[SRC_SUB] & (stop_cnt == STOP_TIMEOUT[$bits(stop_cnt)-1:0]);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stop_cnt <= '0;
      sub_restart <= 1'b0;
    end else begin
      sub_restart <= stop_hit & sub_ctl[SUB_RESTART];
      if (!stop_detector_on || !settled[SRC_SUB] || clk_edge[SRC_SUB] || stop_hit) begin
        stop_cnt <= '0;
      end else begin
        stop_cnt <= stop_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sub_en_q <= 1'b0;
      detect_q <= 1'b0;
    end else begin
      sub_en_q <= src_en[EN_RUN + SRC_SUB];
      detect_q <= sub_ctl[SUB_DETECT];
    end
  end

  // ----------------------------------------------------------------
  // Glitch-free system clock switch
  // ----------------------------------------------------------------
  function automatic logic combo_ok(input logic [1:0] s, input logic [1:0] d);
    case (s)
      SRC_INT, SRC_MAIN: combo_ok = 1'b1;
      SRC_SUB: combo_ok = (d <= 2'h1);
      default: combo_ok = (d == 2'h0);
    endcase
  endfunction : combo_ok

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sys_clk_src <= SRC_INT;
      sys_clk_div <= 2'h0;
    end else if (combo_ok(sys_sel[SEL_SRC +: 2], sys_sel[SEL_DIV +: 2])
                 && osc_run[sys_sel[SEL_SRC +: 2]] && settled[sys_sel[SEL_SRC +: 2]]) begin
      sys_clk_src <= sys_sel[SEL_SRC +: 2];
      sys_clk_div <= sys_sel[SEL_DIV +: 2];
    end
  end

  // ----------------------------------------------------------------
  // Interrupt flags, enables, protection key
  // ----------------------------------------------------------------
  logic [15:0] flag_set, flag_clr;
  always_comb begin
    flag_set = 16'h0000;
    // Internal flag only on a fresh settle
    flag_set[FLG_INT_SET] = settle_hit[SRC_INT];
    flag_set[FLG_SUB_SET] = settle_hit[SRC_SUB];
    flag_set[FLG_MAIN_SET] = settle_hit[SRC_MAIN];
    flag_set[FLG_TRIM] = trim_edge;
    flag_set[FLG_SUB_STOP] = stop_hit | (sub_en_q & ~src_en[EN_RUN + SRC_SUB]) | (detect_q & ~sub_ctl[SUB_DETECT]);
    flag_clr = (wr_fire && avs_address == OFS_FLAGS) ? (avs_writedata[15:0] & MSK_IRQ & lane) : 16'h0000;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flags <= RST_ZERO;
      irq_en <= RST_ZERO;
      prot_key <= RST_ZERO;
    end else begin
      flags <= (flags & ~flag_clr) | flag_set;
      if (wr_fire && avs_address == OFS_IRQ_EN) begin
        irq_en <= merge(irq_en, MSK_IRQ & lane);
      end
      if (wr_fire && avs_address == OFS_KEY) begin
        prot_key <= merge(prot_key, lane);
      end
    end
  end

  // Request only for enabled set flags
  assign irq = |(flags & irq_en);
endmodule : clkg_ctrl

// ==== clkg_ctrl_asserts.sv ====
// Port-level checker for the clock generator control block
`timescale 1ns/10ps
module clkg_ctrl_chk (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic sleep_req,
  input wire logic wakeup,
  input wire logic [3:0] osc_run,
  input wire logic [1:0] sys_clk_src,
  input wire logic [1:0] sys_clk_div,
  input wire logic sleeping,
  input wire logic trim_run,
  input wire logic stop_detector_on,
  input wire logic sub_restart
);
  import clkg_pkg::*;
  logic [3:0] run_q;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Previous run state, so a switch can be tied to a running source
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      run_q <= 4'h1;
    end else begin
      run_q <= osc_run;
    end
  end
  // ----
  // Assertions
  // ----
  wait_state_a: assert property ($rose(avs_read | avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer not after one wait state");
  read_upper_a: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  trim_sub_a: assert property (trim_run |-> osc_run[1])
    else $error("trimming while sub oscillator stopped");
  combo_legal_a: assert property (!(sys_clk_src == SRC_SUB && sys_clk_div[1]) &&
    !(sys_clk_src == SRC_EXT && sys_clk_div != 2'h0)) else $error("reserved clock selection applied");
  switch_run_a: assert property (sys_clk_src != $past(sys_clk_src) |-> run_q[sys_clk_src])
    else $error("switched to a source that was not running");
  restart_pulse_a: assert property (sub_restart |=> !sub_restart)
    else $error("restart longer than one cycle");
  restart_det_a: assert property (sub_restart |-> stop_detector_on)
    else $error("restart without stop detector");
  sleep_enter_a: assert property (sleep_req && !sleeping |=> sleeping)
    else $error("sleep request not taken");
  wake_exit_a: assert property (sleeping && wakeup |=> !sleeping)
    else $error("wake-up not taken");
  boot_run_a: assert property ($fell(rst) |-> osc_run == 4'h1)
    else $error("wrong sources running after reset");
  cover property (sub_restart);
  cover property ($rose(sleeping));
  cover property (sys_clk_src != $past(sys_clk_src));
endmodule : clkg_ctrl_chk
bind clkg_ctrl clkg_ctrl_chk clkg_ctrl_chk_inst (.clk_sys, .rst, .avs_read, .avs_write, .avs_readdata,
  .avs_waitrequest, .sleep_req, .wakeup, .osc_run, .sys_clk_src, .sys_clk_div, .sleeping, .trim_run,
  .stop_detector_on, .sub_restart);

// ==== clkg_osc_model.sv ====
// Model of the oscillator cores and the trimmer beside the control block
`timescale 1ns/10ps
module clkg_osc_model #(
  parameter int TRIM_CYC = 40
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0] osc_run,
  input wire logic trim_run,
  input wire logic sub_hold,
  output logic [3:0] osc_clk_in,
  output logic trim_done_in
);
  logic [1:0] phase;
  int tcnt;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      phase <= 2'h0;
      osc_clk_in <= 4'h0;
    end else begin
      phase <= phase + 2'h1;
      // Sub clock held low to fake a stop
      osc_clk_in <= osc_run & {4{phase[1]}} & {2'h3, ~sub_hold, 1'b1};
    end
  end
  // Trimmer finishes only while trimming runs
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tcnt <= 0;
      trim_done_in <= 1'b0;
    end else if (!trim_run) begin
      tcnt <= 0;
      trim_done_in <= 1'b0;
    end else if (tcnt == TRIM_CYC) begin
      trim_done_in <= 1'b1;
    end else begin
      tcnt <= tcnt + 1;
    end
  end
endmodule : clkg_osc_model

// ==== test_clock_generator_control.sv ====
// Self-checking bench of the clock generator control block
`timescale 1ns/10ps
module test_clock_generator_control;
  import clkg_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0] avs_byteenable = 4'h3;
  logic sleep_req = 1'b0;
  logic wakeup = 1'b0;
  logic sub_hold = 1'b0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, trim_done_in, sleeping, trim_run, stop_detector_on, sub_restart, irq;
  logic [3:0] osc_clk_in, osc_run;
  logic [1:0] sys_clk_src, sys_clk_div, internal_freq_sel, sub_gain, main_gain_sel;
  logic [2:0] gate_cap_sel;
  logic [15:0] rd;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  int i;
  clkg_ctrl #(.STOP_TIMEOUT(64)) clkg_ctrl_inst (.clk_sys, .rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .sleep_req, .wakeup, .osc_clk_in,
    .trim_done_in, .osc_run, .sys_clk_src, .sys_clk_div, .sleeping, .internal_freq_sel, .trim_run,
    .gate_cap_sel, .sub_gain, .main_gain_sel, .stop_detector_on, .sub_restart, .irq);
  clkg_osc_model clkg_osc_model_inst (.clk_sys, .rst, .osc_run, .trim_run, .sub_hold, .osc_clk_in,
    .trim_done_in);
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  // ----
  // Tasks
  // ----
  task report_and_stop;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop
  task check_sig(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : check_sig
  // Waitrequest sampled at the rising edge, where the slave sees the request
  task bus_write(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_write <= 1'b1;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    @(negedge clk_sys);
  endtask : bus_write
  task check_reg(input logic [5:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[15:0];
    avs_read <= 1'b0;
    check_sig($sformatf("register %h", a), exp, rd);
  endtask : check_reg
  task strobe(input logic wake);
    @(posedge clk_sys);
    wakeup <= wake;
    sleep_req <= ~wake;
    @(posedge clk_sys);
    wakeup <= 1'b0;
    sleep_req <= 1'b0;
    @(negedge clk_sys);
  endtask : strobe
  // Hang guard, well above the sub oscillator settle time
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      failures = failures + 1;
      report_and_stop;
    end
  end
  // ----
  // Tests
  // ----
  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    check_reg(OFS_SYS_SEL, 16'h0000);
    check_reg(OFS_SRC_EN, 16'h0f01);
    check_reg(OFS_INTERNAL_OSCILLATOR, 16'h0001);
    check_reg(OFS_SUB, 16'h5092);
    check_reg(OFS_MAIN, 16'h0036);
    check_reg(OFS_FLAGS, 16'h0000);
    check_reg(6'h20, 16'h0000);
    check_sig("sub gain", 16'h0002, {14'h0, sub_gain});
    $display("reset values test done");
    bus_write(OFS_INTERNAL_OSCILLATOR, 16'h0003);
    check_sig("freq", 16'h0001, {14'h0, internal_freq_sel});
    bus_write(OFS_KEY, 16'h0096);
    bus_write(OFS_INTERNAL_OSCILLATOR, 16'h0003);
    check_sig("freq", 16'h0003, {14'h0, internal_freq_sel});
    bus_write(OFS_KEY, 16'h0000);
    bus_write(OFS_SUB, 16'h0000);
    check_reg(OFS_SUB, 16'h5092);
    bus_write(OFS_KEY, 16'h0096);
    $display("protection test done");
    bus_write(OFS_MAIN, 16'h0010);
    check_sig("main gain", 16'h0001, {14'h0, main_gain_sel});
    bus_write(OFS_IRQ_EN, 16'h0004);
    bus_write(OFS_SRC_EN, 16'h0f05);
    for (i = 0; i < 300 && irq !== 1'b1; i++) @(negedge clk_sys);
    check_reg(OFS_FLAGS, 16'h0004);
    bus_write(OFS_FLAGS, 16'h0000);
    check_reg(OFS_FLAGS, 16'h0004);
    bus_write(OFS_IRQ_EN, 16'h0000);
    check_sig("irq", 16'h0000, {15'h0, irq});
    bus_write(OFS_IRQ_EN, 16'h0004);
    check_sig("irq", 16'h0001, {15'h0, irq});
    bus_write(OFS_FLAGS, 16'h0004);
    check_sig("irq", 16'h0000, {15'h0, irq});
    $display("interrupt test done");
    bus_write(OFS_SYS_SEL, 16'h0032);
    for (i = 0; i < 100 && sys_clk_src !== SRC_MAIN; i++) @(negedge clk_sys);
    check_sig("sys sel", 16'h000e, {12'h0, sys_clk_div, sys_clk_src});
    bus_write(OFS_SYS_SEL, 16'h0013);
    repeat (20) @(negedge clk_sys);
    check_sig("sys sel", 16'h000e, {12'h0, sys_clk_div, sys_clk_src});
    bus_write(OFS_SYS_SEL, 16'h0003);
    for (i = 0; i < 100 && sys_clk_src !== SRC_EXT; i++) @(negedge clk_sys);
    check_sig("sys sel", 16'h0003, {12'h0, sys_clk_div, sys_clk_src});
    check_reg(OFS_SRC_EN, 16'h0f0d);
    $display("switching test done");
    bus_write(OFS_SRC_EN, 16'h0f09);
    bus_write(OFS_SYS_SEL, 16'h9203);
    strobe(1'b0);
    check_sig("run in sleep", 16'h0000, {12'h0, osc_run});
    check_sig("sleeping", 16'h0001, {15'h0, sleeping});
    strobe(1'b1);
    for (i = 0; i < 300 && {sys_clk_div, sys_clk_src} !== 4'h6; i++) @(negedge clk_sys);
    check_sig("sys sel", 16'h0006, {12'h0, sys_clk_div, sys_clk_src});
    check_reg(OFS_SYS_SEL, 16'h9212);
    check_reg(OFS_SRC_EN, 16'h0f0d);
    bus_write(OFS_SYS_SEL, 16'h3012);
    strobe(1'b0);
    strobe(1'b1);
    repeat (50) @(negedge clk_sys);
    check_reg(OFS_SYS_SEL, 16'h3012);
    check_sig("sys sel", 16'h0006, {12'h0, sys_clk_div, sys_clk_src});
    $display("wake-up test done");
    bus_write(OFS_SUB, 16'h5091);
    bus_write(OFS_FLAGS, 16'h0037);
    bus_write(OFS_IRQ_EN, 16'h0002);
    bus_write(OFS_SRC_EN, 16'h0f0f);
    for (i = 0; i < 20000 && irq !== 1'b1; i++) @(negedge clk_sys);
    check_sig("irq", 16'h0001, {15'h0, irq});
    check_sig("sub gain", 16'h0001, {14'h0, sub_gain});
    bus_write(OFS_FLAGS, 16'h0037);
    bus_write(OFS_INTERNAL_OSCILLATOR, 16'h0013);
    check_reg(OFS_INTERNAL_OSCILLATOR, 16'h0013);
    for (i = 0; i < 300 && trim_run !== 1'b0; i++) @(negedge clk_sys);
    check_reg(OFS_INTERNAL_OSCILLATOR, 16'h0003);
    check_reg(OFS_FLAGS, 16'h0010);
    $display("trimming test done");
    bus_write(OFS_SUB, 16'h7591);
    check_sig("cap", 16'h0005, {13'h0, gate_cap_sel});
    check_sig("detector", 16'h0001, {15'h0, stop_detector_on});
    bus_write(OFS_FLAGS, 16'h0037);
    @(posedge clk_sys);
    sub_hold <= 1'b1;
    for (i = 0; i < 500 && sub_restart !== 1'b1; i++) @(negedge clk_sys);
    check_sig("restart", 16'h0001, {15'h0, sub_restart});
    @(posedge clk_sys);
    sub_hold <= 1'b0;
    check_reg(OFS_FLAGS, 16'h0020);
    bus_write(OFS_FLAGS, 16'h0020);
    bus_write(OFS_SUB, 16'h5591);
    check_reg(OFS_FLAGS, 16'h0020);
    $display("stop detection test done");
    report_and_stop;
  end
endmodule : test_clock_generator_control
